// file: hw/lpsr_consts.svh
// Constants for the self-refresh and partial-array refresh block
// Functional notes
// - Self-refresh entry is clock enable low, select low, bits 0,1 low, 2 high.
// - In self refresh only clock enable matters; internal timer keeps data.
// - At least one internal all-bank refresh within minimum residency.
// - Exit interval counts from first rising edge after clock enable rises.
// - Bank mask holds one bit per bank; masked banks are not refreshed.
// - Unmasked banks refresh only segments left unmasked.
// - Eight segments; each segment bit applies across all banks.
// - Region refreshed only when neither bank nor segment bit is set.
// - Bank mask at mode address 010h, segment mask at 011h, via write.
`ifndef LPSR_CONSTS_SVH
`define LPSR_CONSTS_SVH

// ----------------------------------------
// Mode register addresses
// ----------------------------------------
`define LPSR_MA_BANK_MASK 8'h10
`define LPSR_MA_SEG_MASK 8'h11
`define LPSR_MASK_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPSR_CLK_NS 40
// Minimum self-refresh residency, ns
`define LPSR_RESIDENCY_NS 15
`define LPSR_RESIDENCY_CYC ((`LPSR_RESIDENCY_NS+`LPSR_CLK_NS-1)/`LPSR_CLK_NS)
// Internal refresh timer period, ns
`define LPSR_INT_REF_NS 7800
`define LPSR_INT_REF_CYC (`LPSR_INT_REF_NS/`LPSR_CLK_NS)
// Self-refresh exit interval, ns
`define LPSR_EXIT_NS 140
`define LPSR_EXIT_CYC ((`LPSR_EXIT_NS+`LPSR_CLK_NS-1)/`LPSR_CLK_NS)

`endif

// file: hw/lpsr_pkg.sv
// Types for the self-refresh and partial-array refresh block
package lpsr_pkg;
  typedef enum logic [2:0] {
    LPSR_ACTIVE = 3'b001,
    LPSR_SELF = 3'b010,
    LPSR_EXIT = 3'b100
  } lpsr_state_t;
endpackage

// file: hw/lpsr_sync.sv
// Two-flop synchroniser with edge detect on the synchronised level
`timescale 1ns/1ps
module lpsr_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Asynchronous input
  input wire logic d_in,
  // Synchronised level and its rising edge
  output logic q_out,
  output logic rise_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign q_out = s2_r;
  assign rise_out = s2_r & ~s3_r;
endmodule

// file: hw/lpsr_top.sv
// Self-refresh sequencing and partial-array refresh masking
`timescale 1ns/1ps
`include "lpsr_consts.svh"
module lpsr_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link pins from controller
  input wire logic ck_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [9:0] ca_rise_in,
  input wire logic [9:0] ca_fall_in,
  // Status
  output logic self_refresh_out,
  output logic exit_busy_out,
  output logic refresh_pulse_out,
  output logic [7:0] refresh_bank_out,
  output logic [7:0] refresh_seg_out,
  output logic [7:0] bank_mask_out,
  output logic [7:0] seg_mask_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic ck_q;
  logic ck_rise;
  logic cke_s1_r;
  logic cke_s2_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic [9:0] car_s1_r;
  logic [9:0] car_s2_r;
  logic [9:0] caf_s1_r;
  logic [9:0] caf_s2_r;
  logic cke_prev_r;

  lpsr_sync u_ck (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(ck_in),
    .q_out(ck_q),
    .rise_out(ck_rise)
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cke_s1_r <= 1'b0;
      cke_s2_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      car_s1_r <= 10'h000;
      car_s2_r <= 10'h000;
      caf_s1_r <= 10'h000;
      caf_s2_r <= 10'h000;
    end else begin
      cke_s1_r <= cke_in;
      cke_s2_r <= cke_s1_r;
      cs_s1_r <= cs_n_in;
      cs_s2_r <= cs_s1_r;
      car_s1_r <= ca_rise_in;
      car_s2_r <= car_s1_r;
      caf_s1_r <= ca_fall_in;
      caf_s2_r <= caf_s1_r;
    end
  end

  // Clock enable as seen at the previous link rising edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cke_prev_r <= 1'b0;
    end else if (ck_rise) begin
      cke_prev_r <= cke_s2_r;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic sr_cmd;
  logic mode_write_cmd;
  logic [7:0] mode_write_addr;
  logic [7:0] mode_write_data;
  lpsr_pkg::lpsr_state_t state_r;

  assign sr_cmd = ck_rise && cke_prev_r && !cke_s2_r && !cs_s2_r
    && !car_s2_r[0] && !car_s2_r[1] && car_s2_r[2]
    && (state_r == lpsr_pkg::LPSR_ACTIVE);
  assign mode_write_cmd = ck_rise && cke_s2_r && !cs_s2_r
    && (car_s2_r[3:0] == 4'h0) && (state_r == lpsr_pkg::LPSR_ACTIVE);
  assign mode_write_addr = {car_s2_r[9:4], caf_s2_r[1:0]};
  assign mode_write_data = caf_s2_r[9:2];

  // ----------------------------------------
  // Mask registers
  // ----------------------------------------
  logic [7:0] bank_refresh_mask_r;
  logic [7:0] segment_refresh_mask_r;

  // mode register writes to the masks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank_refresh_mask_r <= `LPSR_MASK_RESET;
      segment_refresh_mask_r <= `LPSR_MASK_RESET;
    end else if (mode_write_cmd) begin
      if (mode_write_addr == `LPSR_MA_BANK_MASK) begin
        bank_refresh_mask_r <= mode_write_data;
      end else if (mode_write_addr == `LPSR_MA_SEG_MASK) begin
        segment_refresh_mask_r <= mode_write_data;
      end
    end
  end

  // ----------------------------------------
  // Self-refresh state machine
  // ----------------------------------------
  localparam int RES_CYC = `LPSR_RESIDENCY_CYC;
  localparam int REF_CYC = `LPSR_INT_REF_CYC;
  localparam int EXIT_CYC = `LPSR_EXIT_CYC;
  logic [15:0] timer_r;
  logic [15:0] exit_cnt_r;
  logic first_ref_r;

  // in self refresh only clock enable is watched
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= lpsr_pkg::LPSR_ACTIVE;
    end else begin
      case (state_r)
        lpsr_pkg::LPSR_ACTIVE: begin
          if (sr_cmd) begin
            state_r <= lpsr_pkg::LPSR_SELF;
          end
        end
        lpsr_pkg::LPSR_SELF: begin
          if (cke_s2_r) begin
            state_r <= lpsr_pkg::LPSR_EXIT;
          end
        end
        lpsr_pkg::LPSR_EXIT: begin
          if (exit_cnt_r >= 16'(EXIT_CYC)) begin
            state_r <= lpsr_pkg::LPSR_ACTIVE;
          end
        end
        default: begin
          state_r <= lpsr_pkg::LPSR_ACTIVE;
        end
      endcase
    end
  end

  // exit interval counted from link rising edges after exit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      exit_cnt_r <= 16'h0000;
    end else if (state_r != lpsr_pkg::LPSR_EXIT) begin
      exit_cnt_r <= 16'h0000;
    end else if (ck_rise) begin
      exit_cnt_r <= exit_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Internal refresh timer
  // ----------------------------------------
  logic ref_tick;
  logic [2:0] seg_idx_r;
  logic [7:0] seg_bit;

  // first refresh within minimum residency, then periodic
  assign ref_tick = (state_r == lpsr_pkg::LPSR_SELF)
    && (first_ref_r ? (timer_r >= 16'(RES_CYC - 1))
                    : (timer_r >= 16'(REF_CYC - 1)));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      timer_r <= 16'h0000;
      first_ref_r <= 1'b1;
    end else if (state_r != lpsr_pkg::LPSR_SELF) begin
      timer_r <= 16'h0000;
      first_ref_r <= 1'b1;
    end else if (ref_tick) begin
      timer_r <= 16'h0000;
      first_ref_r <= 1'b0;
    end else begin
      timer_r <= timer_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seg_idx_r <= 3'h0;
    end else if (ref_tick) begin
      seg_idx_r <= seg_idx_r + 3'h1;
    end
  end

  // bit n maps to segment n
  assign seg_bit = 8'h01 << seg_idx_r;

  // ----------------------------------------
  // Refresh outputs
  // ----------------------------------------
  // refresh only where neither mask bit is set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      refresh_pulse_out <= 1'b0;
      refresh_bank_out <= 8'h00;
      refresh_seg_out <= 8'h00;
    end else begin
      refresh_pulse_out <= ref_tick;
      refresh_seg_out <= 8'h00;
      refresh_bank_out <= 8'h00;
      if (ref_tick && ((seg_bit & segment_refresh_mask_r) == 8'h00)) begin
        refresh_seg_out <= seg_bit;
        refresh_bank_out <= ~bank_refresh_mask_r;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      self_refresh_out <= 1'b0;
      exit_busy_out <= 1'b0;
      bank_mask_out <= `LPSR_MASK_RESET;
      seg_mask_out <= `LPSR_MASK_RESET;
    end else begin
      self_refresh_out <= (state_r == lpsr_pkg::LPSR_SELF);
      exit_busy_out <= (state_r == lpsr_pkg::LPSR_EXIT);
      bank_mask_out <= bank_refresh_mask_r;
      seg_mask_out <= segment_refresh_mask_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_entry_decode: assert property (
    @(posedge clk_in) disable iff (rst_in)
    sr_cmd |=> state_r == lpsr_pkg::LPSR_SELF)
    else $error("entry not taken");
  a_masked_bank: assert property (
    @(posedge clk_in) disable iff (rst_in)
    refresh_pulse_out |-> (refresh_bank_out & bank_mask_out) == 8'h00)
    else $error("masked bank refreshed");
  a_masked_seg: assert property (
    @(posedge clk_in) disable iff (rst_in)
    refresh_pulse_out |-> (refresh_seg_out & seg_mask_out) == 8'h00)
    else $error("masked segment refreshed");
  a_no_ref_out: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !$past(state_r == lpsr_pkg::LPSR_SELF) |-> !refresh_pulse_out)
    else $error("refresh outside self refresh");
  a_first_ref: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_r == lpsr_pkg::LPSR_SELF && first_ref_r)
    |-> timer_r < 16'(RES_CYC))
    else $error("late first refresh");
  a_exit_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_r == lpsr_pkg::LPSR_EXIT && exit_cnt_r < 16'(EXIT_CYC))
    |=> state_r == lpsr_pkg::LPSR_EXIT)
    else $error("exit interval cut short");
  a_mode_write_bank: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (mode_write_cmd && mode_write_addr == `LPSR_MA_BANK_MASK)
    |=> bank_refresh_mask_r == $past(mode_write_data))
    else $error("bank mask not written");
  a_mode_write_seg: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (mode_write_cmd && mode_write_addr == `LPSR_MA_SEG_MASK)
    |=> segment_refresh_mask_r == $past(mode_write_data))
    else $error("segment mask not written");
  a_self_flag: assert property (
    @(posedge clk_in) disable iff (rst_in)
    self_refresh_out == $past(state_r == lpsr_pkg::LPSR_SELF))
    else $error("self refresh flag out of step");
  a_busy_flag: assert property (
    @(posedge clk_in) disable iff (rst_in)
    exit_busy_out == $past(state_r == lpsr_pkg::LPSR_EXIT))
    else $error("exit busy flag out of step");
  a_masks_frozen: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_r != lpsr_pkg::LPSR_ACTIVE |=> ($stable(bank_refresh_mask_r)
    && $stable(segment_refresh_mask_r)))
    else $error("mask changed outside active state");
  a_stay_self: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_r == lpsr_pkg::LPSR_SELF && !cke_s2_r)
    |=> state_r == lpsr_pkg::LPSR_SELF)
    else $error("self refresh left with clock enable low");
  a_ref_period: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_r == lpsr_pkg::LPSR_SELF && !first_ref_r)
    |-> timer_r < 16'(REF_CYC))
    else $error("internal refresh period overrun");
  a_pulse_single: assert property (
    @(posedge clk_in) disable iff (rst_in)
    refresh_pulse_out |=> !refresh_pulse_out)
    else $error("refresh pulse longer than one cycle");
  a_seg_onehot: assert property (
    @(posedge clk_in) disable iff (rst_in)
    refresh_seg_out != 8'h00 |-> $onehot(refresh_seg_out))
    else $error("more than one segment refreshed");
  a_seg_banks: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (refresh_pulse_out && refresh_seg_out != 8'h00)
    |-> refresh_bank_out == ~bank_mask_out)
    else $error("unmasked banks not refreshed");
  a_region_masked: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (refresh_pulse_out && refresh_seg_out == 8'h00)
    |-> refresh_bank_out == 8'h00)
    else $error("bank refreshed in masked segment");
  a_seg_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ref_tick |-> seg_bit[seg_idx_r])
    else $error("segment bit mismatch");
endmodule

// file: test/lpsr_ctrl_model.sv
// Memory controller model driving the link pins of the block
`timescale 1ns/1ps
module lpsr_ctrl_model (
  // Clock
  input wire logic clk_in,
  // Link pins
  output logic ck_out,
  output logic cke_out,
  output logic cs_n_out,
  output logic [9:0] ca_r_out,
  output logic [9:0] ca_f_out
);
  initial begin
    ck_out = 1'b0;
    cke_out = 1'b1;
    cs_n_out = 1'b1;
    ca_r_out = 10'h000;
    ca_f_out = 10'h000;
  end
  // One link period of 8 clk_in cycles, started at a clk_in rising edge
  task automatic cyc(input logic cke, input logic cs_n,
                     input logic [9:0] r, input logic [9:0] f);
    cke_out <= cke;
    cs_n_out <= cs_n;
    ca_r_out <= r;
    ca_f_out <= f;
    repeat (4) @(posedge clk_in);
    ck_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    // Released lines do not keep their last value
    ca_r_out <= ~r;
    ca_f_out <= ~f;
    @(posedge clk_in);
    ck_out <= 1'b0;
  endtask
  task automatic no_operation(input logic cke);
    cyc(cke, 1'b1, ~ca_r_out, ~ca_f_out);
  endtask
  task automatic mode_register_write(input logic [7:0] addr,
                                     input logic [7:0] data);
    cyc(1'b1, 1'b0, {addr[7:2], 4'h0}, {data, addr[1:0]});
    no_operation(1'b1);
  endtask
  task automatic enter();
    // short refresh burst right before entry
    repeat (2) cyc(1'b1, 1'b0, 10'h004, 10'h000);
    no_operation(1'b1);
    cyc(1'b0, 1'b0, 10'h004, 10'h000);
    no_operation(1'b0);
  endtask
  task automatic leave(input int n);
    repeat (2) no_operation(1'b0);
    repeat (n) no_operation(1'b1);
    // one all-bank refresh instead of eight per-bank ones
    cyc(1'b1, 1'b0, 10'h004, 10'h000);
    no_operation(1'b1);
  endtask
endmodule

// file: test/lpsr_top_bench.sv
// Self-checking bench for the self-refresh and masking block
`timescale 1ns/1ps
module lpsr_top_bench;
  logic clk_in;
  logic rst_in;
  logic ck, cke, cs_n, sr, busy, pulse;
  logic [9:0] ca_r, ca_f;
  logic [7:0] rbank, rseg, bmask, smask;
  int err_count;
  int check_count;
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;
  lpsr_ctrl_model lpsr_ctrl_model_inst (.clk_in(clk_in), .ck_out(ck),
    .cke_out(cke), .cs_n_out(cs_n), .ca_r_out(ca_r), .ca_f_out(ca_f));
  lpsr_top lpsr_top_inst (.clk_in(clk_in), .rst_in(rst_in), .ck_in(ck),
    .cke_in(cke), .cs_n_in(cs_n), .ca_rise_in(ca_r), .ca_fall_in(ca_f),
    .self_refresh_out(sr), .exit_busy_out(busy),
    .refresh_pulse_out(pulse), .refresh_bank_out(rbank),
    .refresh_seg_out(rseg), .bank_mask_out(bmask), .seg_mask_out(smask));
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait on sr, busy or pulse at falling edges
  task automatic wait_for(input int sel, input logic val, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ((sel == 0 ? sr : sel == 1 ? busy : pulse) === val) return;
      @(negedge clk_in);
    end
    err_count++;
    $display("CHECK FAILED wait %0d expected %h seen timeout", sel, val);
    report_and_stop();
  endtask
  task automatic test_masks();
    check("idle state", {5'h00, sr, busy, pulse}, 8'h00);
    check("bank mask reset", bmask, 8'h00);
    check("seg mask reset", smask, 8'h00);
    lpsr_ctrl_model_inst.mode_register_write(8'h10, 8'h82);
    lpsr_ctrl_model_inst.mode_register_write(8'h11, 8'h84);
    lpsr_ctrl_model_inst.mode_register_write(8'h12, 8'h5a);
    check("bank mask", bmask, 8'h82);
    check("seg mask", smask, 8'h84);
    $display("masks test done");
  endtask
  task automatic test_self_refresh();
    logic [7:0] exp_seg;
    logic [7:0] exp_bank;
    fork
      lpsr_ctrl_model_inst.enter();
      begin
        wait_for(0, 1'b1, 60);
        for (int i = 0; i < 8; i++) begin
          exp_seg = (8'h01 << i) & 8'h7b;
          exp_bank = (exp_seg != 8'h00) ? 8'h7d : 8'h00;
          wait_for(2, 1'b1, (i == 0) ? 20 : 250);
          check("banks refreshed", rbank, exp_bank);
          check("seg refreshed", rseg, exp_seg);
          // Step past this one-cycle pulse
          @(negedge clk_in);
        end
      end
    join
    @(posedge clk_in);
    lpsr_ctrl_model_inst.cyc(1'b0, 1'b0, 10'h040, 10'h000);
    check("mask kept", bmask, 8'h82);
    check("still in self refresh", {7'h00, sr}, 8'h01);
    $display("self refresh test done");
  endtask
  task automatic test_exit();
    int n;
    logic prev;
    logic seen;
    n = 0;
    prev = 1'b0;
    seen = 1'b0;
    fork
      lpsr_ctrl_model_inst.leave(6);
      for (int k = 0; k < 200; k++) begin
        @(negedge clk_in);
        if (cke && ck && !prev) n++;
        prev = ck;
        if (busy === 1'b1) seen = 1'b1;
        if (seen && busy === 1'b0) break;
      end
    join
    check("exit busy seen", {7'h00, seen}, 8'h01);
    check("exit link edges", n[7:0], 8'h04);
    check("self refresh left", {7'h00, sr}, 8'h00);
    lpsr_ctrl_model_inst.mode_register_write(8'h10, 8'h00);
    check("bank mask after exit", bmask, 8'h00);
    $display("exit test done");
  endtask
  initial begin
    err_count = 0;
    check_count = 0;
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    test_masks();
    test_self_refresh();
    test_exit();
    report_and_stop();
  end
endmodule
